// [rtl/tcca_pkg.sv]
// package: register map, field layout, bus carriers and state of the timer control block
package tcca_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BUSY = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_DBG = 8'h0C;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // control field layout and encodings
  typedef struct packed {
    logic [20:0] rsvd;
    logic [2:0] on_prescaled_tick_sel;
    logic clock_on_request;
    logic standby_run;
    logic [1:0] wrap_sync_select;
    logic [1:0] width_select;
    logic enable;
    logic soft_reset;
  } tcca_ctrl_t;

  localparam tcca_ctrl_t CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_ON_PRESCALED_TICK_LSB = 8;

  localparam logic [1:0] WIDTH_SIXTEEN = 2'h0;
  localparam logic [1:0] WIDTH_EIGHT = 2'h1;
  localparam logic [1:0] WIDTH_THIRTY_TWO = 2'h2;

  localparam logic [1:0] ON_GENERIC_TICK = 2'h0;
  localparam logic [1:0] ON_PRESCALED_TICK = 2'h1;
  localparam logic [1:0] CLEAR_PRESCALER_ON_WRAP = 2'h2;

  localparam logic [31:0] TOP_EIGHT = 32'h0000_00FF;
  localparam logic [31:0] TOP_SIXTEEN = 32'h0000_FFFF;
  localparam logic [31:0] TOP_THIRTY_TWO = 32'hFFFF_FFFF;

  // sync busy flag positions
  localparam int BUSY_SOFT_RESET_BIT = 0;
  localparam int BUSY_ENABLE_BIT = 1;

  // countdown loaded at the start of the crossing into the timer clock domain, which lasts one cycle longer than this value
  localparam logic [2:0] SYNC_CYCLES = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler
  localparam logic [9:0] ON_PRESCALED_TICK_RESET = 10'h000;

  function automatic logic [9:0] tcca_on_prescaled_tick_mask(input logic [2:0] sel);
    logic [9:0] m;
    m = 10'h000;
    unique case (sel)
      3'h0: m = 10'h000;
      3'h1: m = 10'h001;
      3'h2: m = 10'h003;
      3'h3: m = 10'h007;
      3'h4: m = 10'h00F;
      3'h5: m = 10'h03F;
      3'h6: m = 10'h0FF;
      3'h7: m = 10'h3FF;
    endcase
    return m;
  endfunction

  typedef struct packed {
    logic [9:0] cnt;
  } tcca_on_prescaled_tick_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // bus carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } tcca_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcca_axi_rsp_t;

  ////////////////////////////////////////////////////////////////////////////
  // core state
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    tcca_ctrl_t ctrl;
    logic dbg_run;
    logic busy_soft_reset;
    logic busy_enable;
    logic [2:0] sync_cnt;
    logic enable_active;
    logic [31:0] count;
    logic wrap_pulse;
    logic running;
    logic clock_request;
    logic standby_meta;
    logic standby_sync;
    logic debug_meta;
    logic debug_sync;
  } tcca_state_t;

endpackage

// [rtl/tcca_prescaler.sv]
// prescaler: divides the timer clock and gives one tick per divided period
`timescale 1ns/1ps
`default_nettype none
module tcca_prescaler
  import tcca_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic [2:0] div_sel,
  // tick
  output logic tick
);

  tcca_on_prescaled_tick_state_t s_reg;
  tcca_on_prescaled_tick_state_t s_next;
  logic [9:0] mask;

  always_comb begin
    mask = tcca_on_prescaled_tick_mask(div_sel);
    s_next = s_reg;
    tick = run && ((s_reg.cnt & mask) == mask);
    if (clear) begin
      s_next.cnt = ON_PRESCALED_TICK_RESET;
    end else if (run) begin
      s_next.cnt = (s_reg.cnt & mask) == mask ? ON_PRESCALED_TICK_RESET : 10'(s_reg.cnt + 10'h001);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg <= '{cnt: ON_PRESCALED_TICK_RESET};
    end else begin
      s_reg <= s_next;
    end
  end

endmodule
`default_nettype wire

// [rtl/tcca_timer_control.sv]
// timer control block: AXI4-Lite registers, sync handshake, prescaled counter
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tcca_timer_control
  import tcca_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register bus
  input wire tcca_axi_req_t axi_req,
  output tcca_axi_rsp_t axi_rsp,
  // device state pins
  input wire logic standby_pin,
  input wire logic debug_halt_pin,
  // timer outputs
  output logic [31:0] count_value,
  output logic wrap_pulse,
  output logic counter_running,
  output logic clock_request
);

  tcca_state_t s_reg;
  tcca_state_t s_next;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic sync_done;
  logic run;
  logic tick;
  logic on_prescaled_tick_clear;
  logic [31:0] top;
  logic [1:0] wrap_eff;
  logic on_req_eff;

  tcca_prescaler tcca_prescaler_inst (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(run),
    .clear(on_prescaled_tick_clear),
    .div_sel(s_reg.ctrl.on_prescaled_tick_sel),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    axi_rsp.awready = !s_reg.aw_held && !s_reg.bvalid;
    axi_rsp.wready = !s_reg.w_held && !s_reg.bvalid;
    axi_rsp.bvalid = s_reg.bvalid;
    axi_rsp.bresp = s_reg.bresp;
    axi_rsp.arready = !s_reg.rvalid;
    axi_rsp.rvalid = s_reg.rvalid;
    axi_rsp.rdata = s_reg.rdata;
    axi_rsp.rresp = s_reg.rresp;
  end

  assign count_value = s_reg.count;
  assign wrap_pulse = s_reg.wrap_pulse;
  assign counter_running = s_reg.running;
  assign clock_request = s_reg.clock_request;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.wrap_pulse = 1'b0;
    on_prescaled_tick_clear = 1'b0;
    aw_fire = axi_req.awvalid && axi_rsp.awready;
    w_fire = axi_req.wvalid && axi_rsp.wready;
    ar_fire = axi_req.arvalid && axi_rsp.arready;
    do_write = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
    sync_done = (s_reg.busy_soft_reset || s_reg.busy_enable) && s_reg.sync_cnt == 3'h0;

    // pin synchronisers
    s_next.standby_meta = standby_pin;
    s_next.standby_sync = s_reg.standby_meta;
    s_next.debug_meta = debug_halt_pin;
    s_next.debug_sync = s_reg.debug_meta;

    // reserved codes fall back to the default setting
    wrap_eff = s_reg.ctrl.wrap_sync_select == 2'h3 ? ON_GENERIC_TICK : s_reg.ctrl.wrap_sync_select;
    unique case (s_reg.ctrl.width_select)
      WIDTH_EIGHT: top = TOP_EIGHT;
      WIDTH_THIRTY_TWO: top = TOP_THIRTY_TWO;
      default: top = TOP_SIXTEEN;
    endcase

    // counting
    run = s_reg.enable_active && !(s_reg.standby_sync && !s_reg.ctrl.standby_run)
      && !(s_reg.debug_sync && !s_reg.dbg_run);
    s_next.running = run;
    if (run) begin
      if (s_reg.count >= top) begin
        if (wrap_eff == ON_PRESCALED_TICK) begin
          if (tick) begin
            s_next.count = 32'h0000_0000;
            s_next.wrap_pulse = 1'b1;
          end
        end else begin
          s_next.count = 32'h0000_0000;
          s_next.wrap_pulse = 1'b1;
          on_prescaled_tick_clear = wrap_eff == CLEAR_PRESCALER_ON_WRAP;
        end
      end else if (tick) begin
        s_next.count = 32'(s_reg.count + 32'h0000_0001);
      end
    end

    // clock request when stopped
    on_req_eff = s_reg.ctrl.clock_on_request && !(s_reg.standby_sync && !s_reg.ctrl.standby_run);
    s_next.clock_request = run || !on_req_eff;

    // crossing into the timer domain completes
    if (s_reg.busy_soft_reset || s_reg.busy_enable) begin
      s_next.sync_cnt = sync_done ? 3'h0 : 3'(s_reg.sync_cnt - 3'h1);
    end
    if (sync_done) begin
      if (s_reg.busy_soft_reset) begin
        s_next.ctrl = CTRL_RESET;
        s_next.count = 32'h0000_0000;
        s_next.enable_active = 1'b0;
        s_next.running = 1'b0;
        s_next.busy_soft_reset = 1'b0;
        s_next.busy_enable = 1'b0;
        s_next.wrap_pulse = 1'b0;
        on_prescaled_tick_clear = 1'b1;
      end else begin
        s_next.enable_active = s_reg.ctrl.enable;
        s_next.busy_enable = 1'b0;
      end
    end

    // write channel
    if (aw_fire) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = axi_req.awaddr;
    end
    if (w_fire) begin
      s_next.w_held = 1'b1;
      s_next.w_data = axi_req.wdata;
      s_next.w_strb = axi_req.wstrb;
    end
    if (s_reg.bvalid && axi_req.bready) begin
      s_next.bvalid = 1'b0;
    end
    if (do_write) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      unique case (s_reg.aw_addr)
        ADDR_CTRL: begin
          if (!s_reg.busy_soft_reset && s_reg.w_strb[0]) begin
            if (s_reg.w_data[0]) begin
              s_next.ctrl.soft_reset = 1'b1;
              s_next.busy_soft_reset = 1'b1;
              s_next.sync_cnt = SYNC_CYCLES;
            end else begin
              s_next.ctrl.enable = s_reg.w_data[1];
              s_next.ctrl.width_select = s_reg.w_data[3:2];
              s_next.ctrl.wrap_sync_select = s_reg.w_data[5:4];
              s_next.ctrl.standby_run = s_reg.w_data[6];
              s_next.ctrl.clock_on_request = s_reg.w_data[7];
              s_next.busy_enable = 1'b1;
              s_next.sync_cnt = SYNC_CYCLES;
            end
          end
          if (!s_reg.busy_soft_reset && s_reg.w_strb[1] && !(s_reg.w_strb[0] && s_reg.w_data[0])) begin
            s_next.ctrl.on_prescaled_tick_sel = s_reg.w_data[CTRL_ON_PRESCALED_TICK_LSB +: 3];
          end
        end
        ADDR_DBG: begin
          if (s_reg.w_strb[0]) begin
            s_next.dbg_run = s_reg.w_data[0];
          end
        end
        ADDR_BUSY, ADDR_COUNT: begin
          s_next.bresp = RESP_OKAY;
        end
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end

    // read channel
    if (s_reg.rvalid && axi_req.rready) begin
      s_next.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      unique case (axi_req.araddr)
        ADDR_CTRL: s_next.rdata = s_reg.ctrl;
        ADDR_BUSY: begin
          s_next.rdata[BUSY_SOFT_RESET_BIT] = s_reg.busy_soft_reset;
          s_next.rdata[BUSY_ENABLE_BIT] = s_reg.busy_enable;
        end
        ADDR_COUNT: s_next.rdata = s_reg.count;
        ADDR_DBG: s_next.rdata[0] = s_reg.dbg_run;
        default: s_next.rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.clock_request <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_enable_busy_set: assert property (
    do_write && s_reg.aw_addr == ADDR_CTRL && s_reg.w_strb[0] && !s_reg.w_data[0] && !s_reg.busy_soft_reset
    |=> s_reg.busy_enable && s_reg.ctrl.enable == $past(s_reg.w_data[1]))
    else $error("enable write did not set busy or read back");

  chk_enable_settles: assert property (
    $rose(s_reg.busy_enable) && !s_reg.busy_soft_reset
    |-> ##[1:8] (!s_reg.busy_enable && s_reg.enable_active == s_reg.ctrl.enable))
    else $error("enable did not take effect after sync");

  chk_cfg_no_busy: assert property (
    do_write && s_reg.aw_addr == ADDR_CTRL && !s_reg.w_strb[0] && !s_reg.busy_enable && !s_reg.busy_soft_reset
    |=> !s_reg.busy_enable && !s_reg.busy_soft_reset)
    else $error("non-sync write set a busy flag");

  chk_reset_priority: assert property (
    do_write && s_reg.aw_addr == ADDR_CTRL && s_reg.w_strb[0] && s_reg.w_data[0] && !s_reg.busy_soft_reset
    |=> s_reg.busy_soft_reset && $stable(s_reg.ctrl.enable) && $stable(s_reg.ctrl.width_select))
    else $error("soft reset write did not discard other bits");

  chk_reset_reads_one: assert property (
    s_reg.busy_soft_reset |-> s_reg.ctrl.soft_reset)
    else $error("soft reset bit not high while busy");

  chk_reset_clears: assert property (
    $fell(s_reg.busy_soft_reset)
    |-> s_reg.ctrl == CTRL_RESET && !s_reg.enable_active && s_reg.count == 32'h0000_0000)
    else $error("soft reset left state behind");

  chk_standby_halt: assert property (
    s_reg.standby_sync && !s_reg.ctrl.standby_run && !sync_done |=> $stable(s_reg.count))
    else $error("counter moved in standby");

  chk_width_eight: assert property (
    s_reg.ctrl.width_select == WIDTH_EIGHT && s_reg.count <= TOP_EIGHT && !do_write
    |=> s_reg.count <= TOP_EIGHT)
    else $error("8-bit counter exceeded its range");

  chk_on_request_off: assert property (
    s_reg.standby_sync && !s_reg.ctrl.standby_run |=> s_reg.clock_request)
    else $error("clock request dropped in standby");

endmodule
`default_nettype wire

// [verif/tb_top.sv]
// testbench: register access, sync handshake, prescaler, standby and soft reset checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tcca_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // clock, reset and design hookup
  logic clk_sys;
  logic reset;
  tcca_axi_req_t req;
  tcca_axi_rsp_t rsp;
  logic standby_pin;
  logic debug_halt_pin;
  logic [31:0] count_value;
  logic wrap_pulse;
  logic counter_running;
  logic clock_request;
  int n_errors;
  int n_checks;
  int cycles;
  logic [31:0] rd;
  logic [31:0] c0;
  logic [31:0] prev;
  int per;
  int divs[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

  tcca_timer_control tcca_timer_control_inst (
    .clk_sys(clk_sys),
    .reset(reset),
    .axi_req(req),
    .axi_rsp(rsp),
    .standby_pin(standby_pin),
    .debug_halt_pin(debug_halt_pin),
    .count_value(count_value),
    .wrap_pulse(wrap_pulse),
    .counter_running(counter_running),
    .clock_request(clock_request)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite master: handshakes judged at the falling edge, released after the rising one
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_t;
    logic w_t;
    logic b_t;
    logic [1:0] resp;
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge clk_sys);
      aw_t = req.awvalid && rsp.awready;
      w_t = req.wvalid && rsp.wready;
      b_t = (rsp.bvalid === 1'b1);
      resp = rsp.bresp;
      @(posedge clk_sys);
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
      if (b_t) req.bready <= 1'b0;
    end
    check({30'h0, resp}, {30'h0, er});
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ar_t;
    logic r_t;
    logic [1:0] resp;
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge clk_sys);
      ar_t = req.arvalid && rsp.arready;
      r_t = (rsp.rvalid === 1'b1);
      d = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clk_sys);
      if (ar_t) req.arvalid <= 1'b0;
      if (r_t) req.rready <= 1'b0;
    end
    check({30'h0, resp}, {30'h0, er});
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_read(a, RESP_OKAY, d);
    check(d, exp);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // cycles that the count stands at one value, from its arrival to the next change
  task automatic measure_stand(input logic [31:0] v, output int p);
    while (count_value !== v) @(negedge clk_sys);
    p = 0;
    do begin
      @(negedge clk_sys);
      p++;
    end while (count_value === v);
  endtask

  // cycles between two successive count changes, phase-aligned to a change first
  task automatic measure_period(output int p);
    logic [31:0] c;
    c = count_value;
    while (count_value === c) @(negedge clk_sys);
    c = count_value;
    p = 0;
    do begin
      @(negedge clk_sys);
      p++;
    end while (count_value === c);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    reset = 1'b1;
    req = '0;
    standby_pin = 1'b0;
    debug_halt_pin = 1'b0;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    wait_cycles(2);
    // reset values and bus errors
    expect_reg(ADDR_CTRL, 32'h0000_0000);
    expect_reg(ADDR_BUSY, 32'h0000_0000);
    check(count_value, 32'h0000_0000);
    check({31'h0, clock_request}, 32'h0000_0001);
    axi_read(8'h10, RESP_SLVERR, rd);
    check(rd, 32'h0000_0000);
    axi_write(8'h10, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    // config-only write never raises a busy flag
    axi_write(ADDR_CTRL, 32'h0000_0300, 4'h2, RESP_OKAY);
    expect_reg(ADDR_BUSY, 32'h0000_0000);
    expect_reg(ADDR_CTRL, 32'h0000_0300);
    // enable reads back at once, busy until the crossing completes
    axi_write(ADDR_CTRL, 32'h0000_000A, 4'h3, RESP_OKAY);
    expect_reg(ADDR_BUSY, 32'h0000_0002);
    expect_reg(ADDR_CTRL, 32'h0000_000A);
    wait_cycles(10);
    expect_reg(ADDR_BUSY, 32'h0000_0000);
    check({31'h0, counter_running}, 32'h0000_0001);
    // every prescaler code, 32-bit counter
    for (int i = 0; i < 8; i++) begin
      axi_write(ADDR_CTRL, 32'h0000_000A | (i << CTRL_ON_PRESCALED_TICK_LSB), 4'h3, RESP_OKAY);
      wait_cycles(10);
      measure_period(per);
      check(per, divs[i]);
    end
    // standby halts the counter, clock request forced on
    axi_write(ADDR_CTRL, 32'h0000_0086, 4'h3, RESP_OKAY);
    wait_cycles(10);
    @(posedge clk_sys);
    standby_pin <= 1'b1;
    wait_cycles(8);
    c0 = count_value;
    wait_cycles(20);
    check(count_value, c0);
    check({31'h0, counter_running}, 32'h0000_0000);
    check({31'h0, clock_request}, 32'h0000_0001);
    // standby run keeps counting; 8-bit width wraps after its top
    axi_write(ADDR_CTRL, 32'h0000_00C6, 4'h3, RESP_OKAY);
    wait_cycles(10);
    c0 = count_value;
    wait_cycles(20);
    check({31'h0, count_value !== c0}, 32'h0000_0001);
    do begin
      prev = count_value;
      @(negedge clk_sys);
    end while (wrap_pulse !== 1'b1);
    check(count_value, 32'h0000_0000);
    check(prev, TOP_EIGHT);
    @(posedge clk_sys);
    standby_pin <= 1'b0;
    // reserved width acts as 16-bit: passes the 8-bit top without wrapping
    axi_write(ADDR_CTRL, 32'h0000_000E, 4'h3, RESP_OKAY);
    wait_cycles(300);
    check({31'h0, count_value > TOP_EIGHT}, 32'h0000_0001);
    // soft reset while running: other bits dropped, debug control kept
    axi_write(ADDR_DBG, 32'h0000_0001, 4'hF, RESP_OKAY);
    axi_write(ADDR_CTRL, 32'h0000_00CB, 4'h3, RESP_OKAY);
    expect_reg(ADDR_CTRL, 32'h0000_000F);
    wait_cycles(10);
    expect_reg(ADDR_CTRL, 32'h0000_0000);
    expect_reg(ADDR_BUSY, 32'h0000_0000);
    check(count_value, 32'h0000_0000);
    check({31'h0, counter_running}, 32'h0000_0000);
    expect_reg(ADDR_DBG, 32'h0000_0001);
    // writing zero to soft reset changes nothing
    axi_write(ADDR_CTRL, 32'h0000_0000, 4'h1, RESP_OKAY);
    wait_cycles(10);
    expect_reg(ADDR_BUSY, 32'h0000_0000);
    expect_reg(ADDR_DBG, 32'h0000_0001);
    // wrap sync modes on an 8-bit counter divided by 4
    axi_write(ADDR_CTRL, 32'h0000_0216, 4'h3, RESP_OKAY);
    measure_stand(TOP_EIGHT, per);
    check(per, 32'h0000_0004);
    axi_write(ADDR_CTRL, 32'h0000_0206, 4'h3, RESP_OKAY);
    measure_stand(TOP_EIGHT, per);
    check(per, 32'h0000_0001);
    axi_write(ADDR_CTRL, 32'h0000_0226, 4'h3, RESP_OKAY);
    measure_stand(TOP_EIGHT, per);
    check(per, 32'h0000_0001);
    measure_stand(32'h0000_0000, per);
    check(per, 32'h0000_0004);
    // soft reset busy flag seen while the crossing is under way
    axi_write(ADDR_CTRL, 32'h0000_0001, 4'h1, RESP_OKAY);
    expect_reg(ADDR_BUSY, 32'h0000_0001);
    wait_cycles(10);
    expect_reg(ADDR_CTRL, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
